// ### rtl/mr_ctrl_pkg.sv
// Constants, timing counts and types of the mode register access controller
package mr_ctrl_pkg;
  // Clock and device timing, in picoseconds; the poll interval is in milliseconds
  localparam int CLK_PS = 25000; // 40 MHz pclk
  localparam int DQSCK_MAX_PS = 5500; // Worst strobe output delay
  localparam int WRITE_TO_READ_DELAY_PS = 7500; // Write to read delay
  localparam int POLL_MS = 100; // Temperature poll interval, keeps 10C/s x (100+32+1) ms under 2C
  localparam int POLL_CYC_PER_MS = 1000000000 / CLK_PS; // Cycles in one millisecond

  // Round a time up to whole cycles, never below one
  function automatic int ru_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] DQSCK_CYC = 8'(ru_cyc(DQSCK_MAX_PS)); // round_up of strobe_output_delay
  localparam logic [7:0] WRITE_TO_READ_DELAY_CYC = 8'(ru_cyc(WRITE_TO_READ_DELAY_PS)); // round_up of write_to_read_delay
  localparam logic [7:0] MRR_CYC = 8'h02; // mrr_cmd_period
  localparam logic [7:0] MRW_CYC = 8'h05; // mrw_cmd_period
  localparam logic [7:0] INIT_CYC = 8'h40; // Hold after the reset-type write

  // Mode register addresses
  localparam logic [7:0] TEMP_MA = 8'h04; // temp_status_register
  localparam logic [7:0] CAL_A_MA = 8'h20; // cal_pattern_a_register
  localparam logic [7:0] CAL_B_MA = 8'h28; // cal_pattern_b_register
  localparam logic [7:0] RESET_MA = 8'h3F; // Reset-type write target

  // Command codes on cmd_addr_bus bits 3:0 at the rising edge
  localparam logic [3:0] MRR_OP = 4'h8;
  localparam logic [3:0] MRW_OP = 4'h0;

  // Calibration patterns, bit n is beat n
  localparam logic [3:0] PAT_A = 4'h5;
  localparam logic [3:0] PAT_B = 4'hC;

  // APB register offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] CFG_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h10;
  localparam logic [7:0] RDATA_OFF = 8'h14;
  localparam logic [7:0] TEMP_OFF = 8'h18;
  localparam logic [7:0] BURST0_OFF = 8'h20;
  localparam logic [7:0] BURST1_OFF = 8'h24;

  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_POLL = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REF = 2;
  localparam int ST_CAL = 3;
  localparam int ST_DQS = 4;

  // Reset values
  localparam logic [3:0] RL_RST = 4'h3;
  localparam logic [3:0] WL_RST = 4'h1;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_RDWAIT, ST_BEAT, ST_MRWGAP} ctl_state_t;
endpackage

// ### rtl/burst_mem.sv
// Small capture memory for read burst words, registered read port
module burst_mem (
  input wire logic pclk, // Clock
  input wire logic ce, // Clock enable
  input wire logic we, // Write strobe
  input wire logic [1:0] waddr, // Write index
  input wire logic [31:0] wdata, // Write word
  input wire logic [1:0] raddr, // Read index
  output logic [31:0] rdata // Registered read word
);
  logic [31:0] mem [4]; // Storage, no reset needed

  // Write and registered read
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // burst_mem

// ### rtl/mr_ctrl.sv
// Mode register read/write controller driving the memory command pins

// Notes on behaviour
// - Read: chip select low, bits 3..0 1000
// - Address: fall bits 1:0, rise bits 9:4
// - Four beats; never interrupt a read
// - Two no-operation cycles after a read
// - Hold writes after read by latency sum
// - Read waits burst_length/2 after reads
// - Read waits write latency sum after writes
// - Truncated bursts use effective burst length
// - Poll temperature often enough for 2C
// - Calibration reads only when banks idle
// - Write: chip select low, bits 3..0 zero
// - Write data on fall bits 9:2
// - Writes only with all banks idle
module mr_ctrl import mr_ctrl_pkg::*; #(
  parameter int POLL_CYCLES = POLL_MS * POLL_CYC_PER_MS // Temperature poll period in cycles
) (
  input wire logic pclk, // Clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic cs_n, // Chip select, active low
  output logic [9:0] ca_rise, // cmd_addr_bus, rising half
  output logic [9:0] ca_fall, // cmd_addr_bus, falling half
  input wire logic [15:0] dq_rise, // Data lines, even beat
  input wire logic [15:0] dq_fall, // Data lines, odd beat
  input wire logic dqs_toggle, // Strobes seen toggling this cycle
  input wire logic rd_cmd_seen, // Array read issued elsewhere
  input wire logic wr_cmd_seen, // Array write issued elsewhere
  input wire logic [4:0] burst_len_eff, // Effective burst length of that command
  input wire logic banks_idle, // All banks idle and precharged
  output logic wr_block, // Array writes must wait
  output logic busy // Command in progress
);
  // Decrement that stops at zero
  function automatic logic [7:0] dec8(input logic [7:0] x);
    return (x == 8'h00) ? 8'h00 : x - 8'h01;
  endfunction
  // Larger of two counts
  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction
  // One beat against its calibration bit, every line the same
  function automatic logic beat_ok(input logic [15:0] w, input logic b);
    return w == {16{b}};
  endfunction

  ctl_state_t state, next_state; // Command sequencer
  logic [7:0] cnt, next_cnt; // Cycles since command
  logic next_cs_n; // Chip select next
  logic [9:0] next_ca_rise, next_ca_fall; // Bus halves next
  logic op_wr, next_op_wr; // Current op is a write
  logic op_poll, next_op_poll; // Current op is a temperature poll
  logic [7:0] op_ma, next_op_ma; // Current register address
  logic [7:0] hold_mrr, next_hold_mrr; // Cycles before a read may go
  logic [7:0] hold_wr, next_hold_wr; // Cycles before array writes
  logic [7:0] hold_mrw, next_hold_mrw; // Cycles before a write may go
  logic [22:0] poll_cnt, next_poll_cnt; // Poll timer
  logic poll_due, next_poll_due; // Poll is owed
  logic req_pend, next_req_pend; // Software request waiting
  logic req_wr; // Software wants a write
  logic [7:0] reg_ma, reg_wdata; // Software address and data
  logic [3:0] rl, wl; // Latencies
  logic poll_en; // Polling enabled
  logic [7:0] rd_byte, next_rd_byte; // Last register value
  logic [7:0] temp_byte, next_temp_byte; // Last temperature status
  logic st_done, st_ref, st_cal, st_dqs; // Sticky status
  logic set_done, set_ref, set_cal, set_dqs; // Status set pulses
  logic go_pulse; // Software start
  logic mem_we; // Capture strobe
  logic [31:0] mem_q; // Capture memory read word
  logic [7:0] first_cyc; // Cycle of first beat
  logic [3:0] pat; // Pattern for this read
  logic is_cal; // Current read is calibration
  logic [7:0] rd_gap; // Read to write spacing
  logic mrr_free; // No array burst holds a read back

  assign first_cyc = {4'h0, rl} + DQSCK_CYC;
  assign is_cal = (op_ma == CAL_A_MA) || (op_ma == CAL_B_MA);
  assign pat = (op_ma == CAL_A_MA) ? PAT_A : PAT_B;
  assign rd_gap = first_cyc + 8'h03; // read_latency+round_up+4/2+1
  assign mem_we = (state == ST_RDWAIT && cnt == first_cyc) || state == ST_BEAT;
  assign busy = state != ST_IDLE;
  assign wr_block = hold_wr != 8'h00;
  // A burst seen this very cycle must hold the read too, the counter only loads at the edge
  assign mrr_free = hold_mrr == 8'h00 && !rd_cmd_seen && !wr_cmd_seen;

  // Sequencer and pin drive, next values
  always_comb begin
    next_state = state;
    next_cnt = cnt + 8'h01;
    next_cs_n = 1'b1; // No-operation unless a command goes out
    next_ca_rise = 10'h000;
    next_ca_fall = 10'h000;
    next_op_wr = op_wr;
    next_op_poll = op_poll;
    next_op_ma = op_ma;
    next_req_pend = req_pend | go_pulse;
    next_rd_byte = rd_byte;
    next_temp_byte = temp_byte;
    set_done = 1'b0;
    set_ref = 1'b0;
    set_cal = 1'b0;
    set_dqs = 1'b0;
    next_poll_cnt = poll_cnt + 23'h000001;
    next_poll_due = poll_due;
    if (!poll_en) begin
      next_poll_cnt = 23'h000000;
    end else if (poll_cnt >= 23'(POLL_CYCLES - 1)) begin
      next_poll_cnt = 23'h000000;
      next_poll_due = 1'b1;
    end
    // Spacing counters; truncated bursts arrive as burst_len_eff
    next_hold_mrr = dec8(hold_mrr);
    next_hold_wr = dec8(hold_wr);
    next_hold_mrw = dec8(hold_mrw);
    if (rd_cmd_seen) begin
      next_hold_mrr = max8(next_hold_mrr, {4'h0, burst_len_eff[4:1]});
    end
    if (wr_cmd_seen) begin
      next_hold_mrr = max8(next_hold_mrr, {4'h0, wl} + 8'h01 + {4'h0, burst_len_eff[4:1]} + WRITE_TO_READ_DELAY_CYC);
    end
    case (state)
      ST_IDLE: begin
        next_cnt = 8'h00;
        if (poll_due && mrr_free) begin
          // Poll wins, it keeps the thermal margin
          next_poll_due = 1'b0;
          next_op_wr = 1'b0;
          next_op_poll = 1'b1;
          next_op_ma = TEMP_MA;
          next_state = ST_CMD;
        end else if (req_pend) begin
          next_op_wr = req_wr;
          next_op_poll = 1'b0;
          next_op_ma = reg_ma;
          if (req_wr && !banks_idle) begin
            next_req_pend = 1'b0; // Write refused with banks active
            set_ref = 1'b1;
          end else if (!req_wr && !banks_idle && (reg_ma == CAL_A_MA || reg_ma == CAL_B_MA)) begin
            next_req_pend = 1'b0; // Calibration read refused
            set_ref = 1'b1;
          end else if ((req_wr && hold_mrw == 8'h00) || (!req_wr && mrr_free)) begin
            next_req_pend = 1'b0;
            next_state = ST_CMD;
          end
        end
        if (next_state == ST_CMD) begin
          next_cs_n = 1'b0;
          next_ca_rise = {next_op_ma[7:2], next_op_wr ? MRW_OP : MRR_OP};
          next_ca_fall = {next_op_wr ? reg_wdata : 8'h00, next_op_ma[1:0]};
        end
      end
      ST_CMD: begin
        next_cnt = 8'h01;
        if (op_wr) begin
          next_state = ST_MRWGAP;
        end else begin
          next_state = ST_RDWAIT;
          next_hold_wr = max8(next_hold_wr, (rd_gap > {4'h0, wl}) ? rd_gap - {4'h0, wl} : 8'h00);
          next_hold_mrw = max8(next_hold_mrw, rd_gap);
        end
      end
      ST_RDWAIT: begin
        // Only no-operations until the burst is
        if (cnt == first_cyc) begin
          next_state = ST_BEAT;
          if (!is_cal) begin
            next_rd_byte = dq_rise[7:0]; // Only low byte of beat 0 is meaningful
            if (op_poll) begin
              next_temp_byte = dq_rise[7:0];
            end
          end else if (!beat_ok(dq_rise, pat[0]) || !beat_ok(dq_fall, pat[1])) begin
            set_cal = 1'b1;
          end
          if (!dqs_toggle) begin
            set_dqs = 1'b1;
          end
        end
      end
      ST_BEAT: begin
        next_state = ST_IDLE;
        set_done = !op_poll;
        if (is_cal && (!beat_ok(dq_rise, pat[2]) || !beat_ok(dq_fall, pat[3]))) begin
          set_cal = 1'b1;
        end
        if (!dqs_toggle) begin
          set_dqs = 1'b1;
        end
      end
      ST_MRWGAP: begin
        // Reset form waits out reinitialisation too
        if (cnt >= ((op_ma == RESET_MA) ? INIT_CYC : MRW_CYC)) begin
          next_state = ST_IDLE;
          set_done = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      cs_n <= 1'b1;
      ca_rise <= 10'h000;
      ca_fall <= 10'h000;
      op_wr <= 1'b0;
      op_poll <= 1'b0;
      op_ma <= 8'h00;
      hold_mrr <= 8'h00;
      hold_wr <= 8'h00;
      hold_mrw <= 8'h00;
      poll_cnt <= 23'h000000;
      poll_due <= 1'b0;
      req_pend <= 1'b0;
      rd_byte <= 8'h00;
      temp_byte <= 8'h00;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      cs_n <= next_cs_n;
      ca_rise <= next_ca_rise;
      ca_fall <= next_ca_fall;
      op_wr <= next_op_wr;
      op_poll <= next_op_poll;
      op_ma <= next_op_ma;
      hold_mrr <= next_hold_mrr;
      hold_wr <= next_hold_wr;
      hold_mrw <= next_hold_mrw;
      poll_cnt <= next_poll_cnt;
      poll_due <= next_poll_due;
      req_pend <= next_req_pend;
      rd_byte <= next_rd_byte;
      temp_byte <= next_temp_byte;
    end
  end

  // Burst words kept for software inspection
  burst_mem u_mem (
    .pclk(pclk),
    .ce(ce),
    .we(mem_we),
    .waddr({1'b0, state == ST_BEAT}),
    .wdata({dq_fall, dq_rise}),
    .raddr({1'b0, paddr == BURST1_OFF}),
    .rdata(mem_q)
  );

  // APB slave; reads take one wait state so read data comes from a flop
  logic wr_acc, rd_first, rd_wait, next_rd_wait, mapped; // Access decode
  logic [31:0] next_prdata; // Read word next
  logic next_req_wr, next_poll_en, next_st_done, next_st_ref, next_st_cal, next_st_dqs; // Register next
  logic [7:0] next_reg_ma, next_reg_wdata; // Register next
  logic [3:0] next_rl, next_wl; // Register next

  assign mapped = paddr inside {CTRL_OFF, ADDR_OFF, WDATA_OFF, CFG_OFF, STAT_OFF, RDATA_OFF, TEMP_OFF,
                                BURST0_OFF, BURST1_OFF};
  assign wr_acc = psel && penable && pwrite;
  assign rd_first = psel && penable && !pwrite && !rd_wait;
  assign pready = !rd_first;
  assign pslverr = psel && penable && pready && !mapped;
  assign go_pulse = wr_acc && paddr == CTRL_OFF && pwdata[CTRL_GO] && !req_pend && state == ST_IDLE;

  // Register file next values
  always_comb begin
    next_rd_wait = rd_first;
    next_prdata = prdata;
    next_req_wr = req_wr;
    next_poll_en = poll_en;
    next_reg_ma = reg_ma;
    next_reg_wdata = reg_wdata;
    next_rl = rl;
    next_wl = wl;
    next_st_done = st_done;
    next_st_ref = st_ref;
    next_st_cal = st_cal;
    next_st_dqs = st_dqs;
    if (wr_acc) begin
      case (paddr)
        CTRL_OFF: begin
          if (go_pulse) begin
            next_req_wr = pwdata[CTRL_WR];
          end
          next_poll_en = pwdata[CTRL_POLL];
        end
        ADDR_OFF: next_reg_ma = pwdata[7:0];
        WDATA_OFF: next_reg_wdata = pwdata[7:0];
        CFG_OFF: begin
          next_rl = pwdata[3:0];
          next_wl = pwdata[7:4];
        end
        STAT_OFF: begin
          // Write one to clear
          next_st_done = st_done & !pwdata[ST_DONE];
          next_st_ref = st_ref & !pwdata[ST_REF];
          next_st_cal = st_cal & !pwdata[ST_CAL];
          next_st_dqs = st_dqs & !pwdata[ST_DQS];
        end
        default: ;
      endcase
    end
    // A set in the clearing cycle wins
    next_st_done = next_st_done | set_done;
    next_st_ref = next_st_ref | set_ref;
    next_st_cal = next_st_cal | set_cal;
    next_st_dqs = next_st_dqs | set_dqs;
    if (rd_first) begin
      case (paddr)
        CTRL_OFF: next_prdata = {29'h0, poll_en, req_wr, req_pend};
        ADDR_OFF: next_prdata = {24'h0, reg_ma};
        WDATA_OFF: next_prdata = {24'h0, reg_wdata};
        CFG_OFF: next_prdata = {24'h0, wl, rl};
        STAT_OFF: next_prdata = {27'h0, st_dqs, st_cal, st_ref, st_done, busy};
        RDATA_OFF: next_prdata = {24'h0, rd_byte};
        TEMP_OFF: next_prdata = {24'h0, temp_byte};
        BURST0_OFF, BURST1_OFF: next_prdata = mem_q;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait <= 1'b0;
      prdata <= 32'h0000_0000;
      req_wr <= 1'b0;
      poll_en <= 1'b0;
      reg_ma <= 8'h00;
      reg_wdata <= 8'h00;
      rl <= RL_RST;
      wl <= WL_RST;
      st_done <= 1'b0;
      st_ref <= 1'b0;
      st_cal <= 1'b0;
      st_dqs <= 1'b0;
    end else if (ce) begin
      rd_wait <= next_rd_wait;
      prdata <= next_prdata;
      req_wr <= next_req_wr;
      poll_en <= next_poll_en;
      reg_ma <= next_reg_ma;
      reg_wdata <= next_reg_wdata;
      rl <= next_rl;
      wl <= next_wl;
      st_done <= next_st_done;
      st_ref <= next_st_ref;
      st_cal <= next_st_cal;
      st_dqs <= next_st_dqs;
    end
  end

  // Checks on what goes out on the pins
  logic cmd_mrr, cmd_mrw; // Command issued this cycle
  assign cmd_mrr = state == ST_CMD && !op_wr;
  assign cmd_mrw = state == ST_CMD && op_wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  chk_mrr_code: assert property (cmd_mrr |-> !cs_n && ca_rise[3:0] == MRR_OP) else $error("bad read code");
  chk_mrw_code: assert property (cmd_mrw |-> !cs_n && ca_rise[3:0] == MRW_OP) else $error("bad write code");
  chk_addr_split: assert property (state == ST_CMD |-> {ca_rise[9:4], ca_fall[1:0]} == op_ma)
    else $error("address split wrong");
  chk_mrw_data: assert property (cmd_mrw |-> ca_fall[9:2] == $past(reg_wdata)) else $error("write data wrong");
  chk_mrr_nop: assert property (cmd_mrr |=> cs_n [*2]) else $error("command inside read period");
  chk_read_whole: assert property (state == ST_RDWAIT || state == ST_BEAT |-> cs_n && busy)
    else $error("read burst interrupted");
  chk_read_bound: assert property (cmd_mrr |-> ##[1:20] state == ST_BEAT) else $error("read burst never done");
  chk_mrw_idle: assert property (cmd_mrw |-> $past(banks_idle)) else $error("write with banks active");
  chk_read_gap: assert property (cmd_mrr |=> hold_mrw == {4'h0, rl} + DQSCK_CYC + 8'h03)
    else $error("read gap not loaded");
  chk_rd_spacing: assert property (rd_cmd_seen |=> !cmd_mrr
    && hold_mrr >= {4'h0, $past(burst_len_eff[4:1])}) else $error("read too soon");
  chk_wr_spacing: assert property (wr_cmd_seen |=> !cmd_mrr
    && hold_mrr >= {4'h0, wl} + 8'h01 + {4'h0, $past(burst_len_eff[4:1])} + WRITE_TO_READ_DELAY_CYC)
    else $error("write spacing short");
  chk_cal_idle: assert property (cmd_mrr && is_cal && !op_poll |-> $past(banks_idle, 1))
    else $error("calibration read with banks active");

  cov_read: cover property (cmd_mrr ##[1:20] set_done);
  cov_write: cover property (cmd_mrw ##[1:80] set_done);
  cov_cal: cover property (cmd_mrr && is_cal ##[1:20] state == ST_BEAT);
  cov_refuse: cover property (set_ref);
endmodule // mr_ctrl

// ### tb/dev_model.sv
// Behavioural memory device answering mode register commands
module dev_model import mr_ctrl_pkg::*; #(
  parameter int RL = 3, // Read latency
  parameter int TSI = 40, // Sensor refresh period
  parameter logic [7:0] TEMP_VAL = 8'h03 // Sensor reading
) (
  input wire logic pclk, // Clock
  input wire logic cs_n, // Select
  input wire logic [9:0] ca_rise, // Rise half
  input wire logic [9:0] ca_fall, // Fall half
  output logic [15:0] dq_rise, // Even beats
  output logic [15:0] dq_fall, // Odd beats
  output logic dqs_toggle // Strobes moving
);
  logic [7:0] mr [256]; // Register file
  logic [7:0] ma, rv; // Address, value
  logic [3:0] pt; // Pattern
  logic cal; // Pattern read
  int d = 0; // Cycles since read
  int t = 0; // Sensor timer
  int n_cmd = 0; // Commands seen
  // Defaults, also after reset-type write
  task automatic clr;
    foreach (mr[i]) mr[i] = 8'h00;
    mr[TEMP_MA] = TEMP_VAL;
  endtask
  initial begin
    clr();
    {dq_rise, dq_fall, dqs_toggle} = '0;
  end
  // Decode at the rising edge, beats rl+1 cycles on
  always @(posedge pclk) begin
    t = (t == TSI - 1) ? 0 : t + 1;
    if (t == 0) mr[TEMP_MA] = TEMP_VAL;
    if (d != 0) d = d + 1;
    if (cs_n === 1'b0) begin
      n_cmd = n_cmd + 1;
      ma = {ca_rise[9:4], ca_fall[1:0]};
      cal = ma == CAL_A_MA || ma == CAL_B_MA;
      if (ca_rise[3:0] == 4'h8) begin
        d = 1;
        rv = mr[ma];
        pt = ma == CAL_A_MA ? 4'h5 : 4'hC;
      end else if (ca_rise[3:0] == 4'h0 && ma == RESET_MA) clr();
      else if (ca_rise[3:0] == 4'h0 && !cal && ma != TEMP_MA) mr[ma] = ca_fall[9:2];
    end
    dqs_toggle <= d == RL + 1 || d == RL + 2;
    if (d == RL + 1) begin
      dq_rise <= cal ? {16{pt[0]}} : {~rv, rv};
      dq_fall <= cal ? {16{pt[1]}} : 16'hC3A5;
    end else if (d == RL + 2) begin
      dq_rise <= cal ? {16{pt[2]}} : 16'h5A3C;
      dq_fall <= cal ? {16{pt[3]}} : 16'h96E1;
      d = 0;
    end else begin
      // Idle lines invert, never hold the last beat
      dq_rise <= ~dq_rise;
      dq_fall <= ~dq_fall;
    end
  end
endmodule // dev_model

// ### tb/testbench.sv
// Self-checking bench for the mode register controller
module testbench import mr_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite, pslverr, pready, cs_n, dqs_toggle, perr;
  logic rd_cmd_seen, wr_cmd_seen, banks_idle, wr_block, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [9:0] ca_rise, ca_fall;
  logic [15:0] dq_rise, dq_fall;
  logic [4:0] burst_len_eff;
  int n_fail = 0;
  int tests_run = 0;
  localparam logic [7:0] TEMP_VAL = 8'h03; // Model sensor reading
  // Short poll period keeps the run brief
  mr_ctrl #(.POLL_CYCLES(50)) mr_ctrl_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cs_n, .ca_rise, .ca_fall, .dq_rise, .dq_fall, .dqs_toggle,
    .rd_cmd_seen, .wr_cmd_seen, .burst_len_eff, .banks_idle, .wr_block, .busy);
  dev_model #(.TEMP_VAL(TEMP_VAL)) dev_model_inst (.pclk, .cs_n, .ca_rise, .ca_fall, .dq_rise,
    .dq_fall, .dqs_toggle);
  always #12.5 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for done or refused, then clear the sticky bits
  task automatic fin;
    int k;
    k = 0;
    do begin
      apb(1'b0, STAT_OFF, 32'h0);
      k++;
    end while (rd[ST_DONE] !== 1'b1 && rd[ST_REF] !== 1'b1 && k < 60);
    if (rd[ST_DONE] !== 1'b1 && rd[ST_REF] !== 1'b1) n_fail++; // Command never finished
    st = rd;
    apb(1'b1, STAT_OFF, 32'h1E);
  endtask
  task automatic mr_op(input logic w, input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, ADDR_OFF, {24'h0, a});
    apb(1'b1, WDATA_OFF, {24'h0, v});
    apb(1'b1, CTRL_OFF, {30'h0, w, 1'b1});
    fin();
  endtask
  task automatic t_poll;
    apb(1'b1, CTRL_OFF, 32'h4);
    repeat (150) @(posedge pclk);
    apb(1'b0, TEMP_OFF, 32'h0);
    check(rd, {24'h0, TEMP_VAL});
    apb(1'b1, CTRL_OFF, 32'h0);
  endtask
  task automatic t_basic;
    int nw, nb;
    nw = 0;
    nb = 0;
    apb(1'b0, CFG_OFF, 32'h0);
    check(rd, 32'h13);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, perr}, 32'h1);
    mr_op(1'b1, 8'hB6, 8'hA7);
    check({24'h0, dev_model_inst.mr[8'hB6]}, 32'hA7);
    // Count cycles of the write hold and of busy around one read
    fork
      mr_op(1'b0, 8'hB6, 8'h00);
      repeat (24) begin
        @(posedge pclk);
        nw += int'(wr_block);
        nb += int'(busy);
      end
    join
    check(st & 32'h1C, 32'h0);
    check(32'(nw), 32'h6);
    check(32'(nb), 32'h6);
    apb(1'b0, RDATA_OFF, 32'h0);
    check(rd, 32'hA7);
    mr_op(1'b1, TEMP_MA, 8'hEE);
    mr_op(1'b0, TEMP_MA, 8'h00);
    apb(1'b0, RDATA_OFF, 32'h0);
    check(rd, {24'h0, TEMP_VAL});
  endtask
  task automatic t_cal;
    logic [7:0] a [2];
    logic [3:0] p [2];
    a = '{CAL_A_MA, CAL_B_MA};
    p = '{4'h5, 4'hC};
    for (int i = 0; i < 2; i++) begin
      mr_op(1'b0, a[i], 8'h00);
      check(st & 32'h1C, 32'h0);
      apb(1'b0, BURST0_OFF, 32'h0);
      check(rd, {{16{p[i][1]}}, {16{p[i][0]}}});
      apb(1'b0, BURST1_OFF, 32'h0);
      check(rd, {{16{p[i][3]}}, {16{p[i][2]}}});
    end
  endtask
  // Array command seen beside our read; cs_n must stay high meanwhile
  task automatic t_space(input logic w, input logic [4:0] bl, input int q);
    int bad;
    bad = 0;
    apb(1'b1, ADDR_OFF, 32'h000000B6);
    fork
      apb(1'b1, CTRL_OFF, 32'h1);
      begin
        repeat (3) @(posedge pclk);
        rd_cmd_seen <= !w;
        wr_cmd_seen <= w;
        burst_len_eff <= bl;
        @(posedge pclk);
        rd_cmd_seen <= 1'b0;
        wr_cmd_seen <= 1'b0;
        repeat (q) begin
          @(posedge pclk);
          if (cs_n === 1'b0) bad++;
        end
      end
    join
    fin();
    check(32'(bad), 32'h0);
  endtask
  task automatic t_banks;
    int n;
    banks_idle <= 1'b0;
    n = dev_model_inst.n_cmd;
    mr_op(1'b1, 8'hB6, 8'h11);
    check(st & 32'h1C, 32'h4);
    mr_op(1'b0, CAL_B_MA, 8'h00);
    check(st & 32'h1C, 32'h4);
    check(32'(dev_model_inst.n_cmd - n), 32'h0);
    mr_op(1'b0, 8'hB6, 8'h00);
    check(st & 32'h1C, 32'h0);
    apb(1'b0, RDATA_OFF, 32'h0);
    check(rd, 32'hA7);
    banks_idle <= 1'b1;
    mr_op(1'b1, RESET_MA, 8'h00);
    mr_op(1'b0, 8'hB6, 8'h00);
    apb(1'b0, RDATA_OFF, 32'h0);
    check(rd, 32'h0);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, rd_cmd_seen, wr_cmd_seen} = '0;
    {paddr, pwdata} = '0;
    ce = 1'b1;
    banks_idle = 1'b1;
    burst_len_eff = 5'h04;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_poll();
    t_basic();
    t_cal();
    t_space(1'b0, 5'h10, 7);
    t_space(1'b1, 5'h08, 6);
    t_banks();
    wrap_up();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
endmodule // testbench
